// ==== core/acs_ctrl.sv ====
// Control decode, mux selection and status word for the converter.
// Assumes host strobes and data arrive asynchronously on pins and
// that the conversion engine drives i_conv_busy on the system clock.
`timescale 1ns/1ps

// Contract
// - Sixteen-bit status word is read-only; writes never alter it.
// - Every stored status bit clears to zero at power-up.
// - Status bits 15 and 14 always read zero.
// - Status bits 7 and 6 read one from the first edge after reset.
// - Status bit 4 is one while converting or calibrating.
// - Status bit 0 is one only while calibration runs.
// - Status bits 13..10 show input config and channel bits.
// - Status bits 9 and 8 show the power saving field.
// - Status bit 5 shows the analog range select bit.
// - Status bit 3 shows calibration type, self or system.
// - Status bits 2 and 1 show the calibration sub-select.
// - Differential mode picks pairs; range sets coding; top bit unused.
// - Single-ended picks 1,3,5,7,2,4,6,8; negative ground or eight.
// - Self type, sub 00: DAC, then gain, then offset.
// - Self sub 01 gain+offset, 10 offset only, 11 gain only.
// - System type, sub 00: DAC, then system gain, then offset.
// - System sub 01 gain+offset, 10 offset only, 11 gain only.
// - Launch bit one starts selected calibration; zero starts none.
// - Input config zero is differential, one is single-ended.
module acs_ctrl (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_clk_en,
  input  wire logic        i_wr_stb,
  input  wire logic        i_rd_stb,
  input  wire logic [15:0] i_wr_data,
  input  wire logic        i_conv_busy,
  output logic      [15:0] o_rd_data,
  output logic             o_rd_valid,
  output logic      [1:0]  o_rd_target,
  output logic      [1:0]  o_power_saving,
  output logic             o_conv_start,
  output logic      [2:0]  o_pos_mux,
  output logic      [2:0]  o_neg_mux,
  output logic             o_neg_is_gnd,
  output logic             o_bipolar,
  output logic             o_chan_unused,
  output logic             o_cal_busy,
  output logic             o_cal_system,
  output logic      [1:0]  o_cal_step,
  output logic      [15:0] o_status
);

  // ----------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------
  logic [1:0]  wr_sync_ff;
  logic [1:0]  rd_sync_ff;
  logic [15:0] dat_meta_ff;
  logic [15:0] dat_sync_ff;
  logic        wr_prev_ff;
  logic        rd_prev_ff;
  logic        wr_pulse;
  logic        rd_pulse;

  // Two stages per pin; only the second stage feeds logic
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_sync_ff  <= '0;
      rd_sync_ff  <= '0;
      dat_meta_ff <= '0;
      dat_sync_ff <= '0;
      wr_prev_ff  <= 1'b0;
      rd_prev_ff  <= 1'b0;
    end else if (i_clk_en) begin
      wr_sync_ff  <= {wr_sync_ff[0], i_wr_stb};
      rd_sync_ff  <= {rd_sync_ff[0], i_rd_stb};
      dat_meta_ff <= i_wr_data;
      dat_sync_ff <= dat_meta_ff;
      wr_prev_ff  <= wr_sync_ff[1];
      rd_prev_ff  <= rd_sync_ff[1];
    end
  end

  // Act on the falling edge of the write strobe: data has had the
  // whole strobe width to settle through its own synchroniser.
  assign wr_pulse = i_clk_en & wr_prev_ff & ~wr_sync_ff[1];
  assign rd_pulse = i_clk_en & rd_sync_ff[1] & ~rd_prev_ff;

  // ----------------------------------------------------------
  // Control word
  // ----------------------------------------------------------
  logic [15:0] ctl_ff;
  logic [15:0] nxt_ctl;
  logic        conv_ff;
  logic        nxt_conv;
  logic        launch;

  acs_cal_if cal_bus ();

  // Launch only on a write with the launch bit set, and only if idle
  assign launch = wr_pulse & dat_sync_ff[acs_pkg::CW_LAUNCH]
                  & ~cal_bus.busy;

  // Every write refreshes all control fields
  always_comb begin
    nxt_ctl  = ctl_ff;
    nxt_conv = 1'b0;
    if (wr_pulse) begin
      nxt_ctl  = dat_sync_ff;
      nxt_conv = dat_sync_ff[acs_pkg::CW_CONV];
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ctl_ff  <= acs_pkg::CW_RESET;
      conv_ff <= 1'b0;
    end else if (i_clk_en) begin
      ctl_ff  <= nxt_ctl;
      conv_ff <= nxt_conv;
    end
  end

  // ----------------------------------------------------------
  // Calibration sequencer
  // ----------------------------------------------------------
  assign cal_bus.start      = launch;
  assign cal_bus.system_cal = dat_sync_ff[acs_pkg::CW_CALTYPE];
  assign cal_bus.sub_sel    =
    dat_sync_ff[acs_pkg::CW_SUB_HI:acs_pkg::CW_SUB_LO];

  acs_cal_seq u_cal_seq (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_clk_en  (i_clk_en),
    .cal       (cal_bus.seq)
  );

  // ----------------------------------------------------------
  // Input mux and coding decode
  // ----------------------------------------------------------
  logic       cfg_single;
  logic [2:0] chan;
  logic       range_sel;
  logic [2:0] nxt_pos;
  logic [2:0] nxt_neg;
  logic       nxt_gnd;
  logic       nxt_bip;
  logic       nxt_unused;

  assign cfg_single = ctl_ff[acs_pkg::CW_CFG];
  assign chan       = ctl_ff[acs_pkg::CW_CH_HI:acs_pkg::CW_CH_LO];
  assign range_sel  = ctl_ff[acs_pkg::CW_RANGE];

  // Mux index 0..7 stands for analog inputs one to eight
  always_comb begin
    nxt_pos    = '0;
    nxt_neg    = '0;
    nxt_gnd    = 1'b0;
    nxt_bip    = 1'b0;
    nxt_unused = 1'b0;
    if (cfg_single) begin
      // Odd inputs first, then even ones
      nxt_pos = {chan[1:0], chan[2]};
      nxt_gnd = ~range_sel;
      nxt_neg = range_sel ? acs_pkg::IN_EIGHT : 3'h0;
      nxt_bip = 1'b0;
    end else begin
      // Pairs 1/2, 3/4, 5/6, 7/8
      nxt_pos    = {chan[1:0], 1'b0};
      nxt_neg    = {chan[1:0], 1'b1};
      nxt_bip    = range_sel;
      nxt_unused = chan[2];
    end
  end

  // ----------------------------------------------------------
  // Status word assembly
  // ----------------------------------------------------------
  logic [15:0] nxt_status;
  logic        any_busy;

  assign any_busy = i_conv_busy | conv_ff | cal_bus.busy;

  // Built only from control mirrors and live state, never from a
  // write aimed at it, so host writes cannot disturb it.
  always_comb begin
    nxt_status = {acs_pkg::ST_ZERO_PAIR,
                  ctl_ff[acs_pkg::CW_CFG:acs_pkg::CW_CH_LO],
                  ctl_ff[acs_pkg::CW_PWR_HI:acs_pkg::CW_PWR_LO],
                  acs_pkg::ST_ONE_PAIR,
                  ctl_ff[acs_pkg::CW_RANGE],
                  any_busy,
                  ctl_ff[acs_pkg::CW_CALTYPE],
                  ctl_ff[acs_pkg::CW_SUB_HI:acs_pkg::CW_SUB_LO],
                  cal_bus.busy};
  end

  // ----------------------------------------------------------
  // Read port
  // ----------------------------------------------------------
  logic [15:0] rd_data_ff;
  logic [15:0] nxt_rd_data;
  logic        rd_valid_ff;

  // Only the status target is answered here; other targets
  // belong to blocks outside and read as zero on this port.
  always_comb begin
    nxt_rd_data = rd_data_ff;
    if (rd_pulse) begin
      if (ctl_ff[acs_pkg::CW_RD_HI:acs_pkg::CW_RD_LO]
          == acs_pkg::RD_TGT_STATUS) begin
        nxt_rd_data = nxt_status;
      end else begin
        nxt_rd_data = acs_pkg::RD_IDLE_DATA;
      end
    end
  end

  // ----------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------
  logic [15:0] status_ff;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      status_ff      <= acs_pkg::ST_RESET;
      rd_data_ff     <= acs_pkg::ST_RESET;
      rd_valid_ff    <= 1'b0;
      o_rd_target    <= '0;
      o_power_saving <= '0;
      o_conv_start   <= 1'b0;
      o_pos_mux      <= '0;
      o_neg_mux      <= '0;
      o_neg_is_gnd   <= 1'b0;
      o_bipolar      <= 1'b0;
      o_chan_unused  <= 1'b0;
      o_cal_busy     <= 1'b0;
      o_cal_system   <= 1'b0;
      o_cal_step     <= '0;
    end else if (i_clk_en) begin
      status_ff      <= nxt_status;
      rd_data_ff     <= nxt_rd_data;
      rd_valid_ff    <= rd_pulse;
      o_rd_target    <= ctl_ff[acs_pkg::CW_RD_HI:acs_pkg::CW_RD_LO];
      o_power_saving <= ctl_ff[acs_pkg::CW_PWR_HI:acs_pkg::CW_PWR_LO];
      o_conv_start   <= nxt_conv;
      o_pos_mux      <= nxt_pos;
      o_neg_mux      <= nxt_neg;
      o_neg_is_gnd   <= nxt_gnd;
      o_bipolar      <= nxt_bip;
      o_chan_unused  <= nxt_unused;
      o_cal_busy     <= cal_bus.busy;
      o_cal_system   <= ctl_ff[acs_pkg::CW_CALTYPE];
      o_cal_step     <= 2'(cal_bus.step);
    end
  end

  assign o_status   = status_ff;
  assign o_rd_data  = rd_data_ff;
  assign o_rd_valid = rd_valid_ff;

endmodule

// ==== include/acs_pkg.sv ====
// Constants for the converter control decode and status block.
// Assumes a 100 MHz system clock and a 16-bit host data port.
package acs_pkg;

  // ----------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Time spent on each calibration step (plain default)
  localparam int unsigned CAL_STEP_NS   = 1000;
  localparam int unsigned CAL_STEP_CYC  =
    (CAL_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STEP_CNT_W    = 8;
  localparam logic [STEP_CNT_W-1:0] STEP_LAST =
    STEP_CNT_W'(CAL_STEP_CYC - 1);

  // ----------------------------------------------------------
  // Control word field positions
  // ----------------------------------------------------------
  localparam int unsigned CW_CFG     = 13;
  localparam int unsigned CW_CH_HI   = 12;
  localparam int unsigned CW_CH_LO   = 10;
  localparam int unsigned CW_PWR_HI  = 9;
  localparam int unsigned CW_PWR_LO  = 8;
  localparam int unsigned CW_RD_HI   = 7;
  localparam int unsigned CW_RD_LO   = 6;
  localparam int unsigned CW_RANGE   = 5;
  localparam int unsigned CW_CONV    = 4;
  localparam int unsigned CW_CALTYPE = 3;
  localparam int unsigned CW_SUB_HI  = 2;
  localparam int unsigned CW_SUB_LO  = 1;
  localparam int unsigned CW_LAUNCH  = 0;

  // ----------------------------------------------------------
  // Status word layout and reset
  // ----------------------------------------------------------
  localparam int unsigned ST_BUSY    = 4;
  localparam int unsigned ST_CAL_RUN = 0;
  localparam logic [1:0]  ST_ZERO_PAIR = 2'h0;
  localparam logic [1:0]  ST_ONE_PAIR  = 2'h3;
  localparam logic [15:0] ST_RESET     = 16'h0000;
  localparam logic [15:0] CW_RESET     = 16'h0000;

  // Read target that returns the status word
  localparam logic [1:0] RD_TGT_STATUS = 2'h3;
  localparam logic [15:0] RD_IDLE_DATA = 16'h0000;

  // Calibration sub-select codes
  localparam logic [1:0] SUB_FULL     = 2'h0;
  localparam logic [1:0] SUB_GAIN_OFS = 2'h1;
  localparam logic [1:0] SUB_OFS      = 2'h2;
  localparam logic [1:0] SUB_GAIN     = 2'h3;

  // Calibration step in progress
  typedef enum logic [1:0] {
    ACS_STEP_NONE,
    ACS_STEP_DAC,
    ACS_STEP_GAIN,
    ACS_STEP_OFFSET
  } acs_step_t;

  // Negative input select: ground or analog input eight
  localparam logic [2:0] IN_EIGHT = 3'h7;

endpackage

// ==== include/acs_cal_if.sv ====
// Carrier between the control decoder and the calibration sequencer.
// Both ends run on the same system clock.
`timescale 1ns/1ps
interface acs_cal_if;
  logic                 start;
  logic                 system_cal;
  logic [1:0]           sub_sel;
  logic                 busy;
  acs_pkg::acs_step_t   step;

  modport ctrl (output start, output system_cal, output sub_sel,
                input busy, input step);
  modport seq  (input start, input system_cal, input sub_sel,
                output busy, output step);
endinterface

// ==== core/acs_cal_seq.sv ====
// Calibration step sequencer: walks DAC, gain and offset steps.
// Assumes start is a one-cycle pulse issued only while idle.
`timescale 1ns/1ps
module acs_cal_seq (
  input  wire logic  i_sys_clk,
  input  wire logic  i_rst,
  input  wire logic  i_clk_en,
  acs_cal_if.seq     cal
);

  // ----------------------------------------------------------
  // Step machine
  // ----------------------------------------------------------
  acs_pkg::acs_step_t                     step_ff;
  acs_pkg::acs_step_t                     nxt_step;
  logic [acs_pkg::STEP_CNT_W-1:0]         cnt_ff;
  logic [acs_pkg::STEP_CNT_W-1:0]         nxt_cnt;
  logic [1:0]                             sub_ff;
  logic [1:0]                             nxt_sub;
  logic                                   sys_ff;
  logic                                   nxt_sys;

  // Next step from the latched selection
  always_comb begin
    nxt_step = step_ff;
    nxt_cnt  = cnt_ff;
    nxt_sub  = sub_ff;
    nxt_sys  = sys_ff;
    unique case (step_ff)
      acs_pkg::ACS_STEP_NONE: begin
        if (cal.start) begin
          nxt_sub = cal.sub_sel;
          nxt_sys = cal.system_cal;
          nxt_cnt = '0;
          unique case (cal.sub_sel)
            acs_pkg::SUB_FULL:     nxt_step = acs_pkg::ACS_STEP_DAC;
            acs_pkg::SUB_GAIN_OFS: nxt_step = acs_pkg::ACS_STEP_GAIN;
            acs_pkg::SUB_OFS:      nxt_step = acs_pkg::ACS_STEP_OFFSET;
            acs_pkg::SUB_GAIN:     nxt_step = acs_pkg::ACS_STEP_GAIN;
          endcase
        end
      end
      acs_pkg::ACS_STEP_DAC: begin
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff == acs_pkg::STEP_LAST) begin
          nxt_cnt  = '0;
          nxt_step = acs_pkg::ACS_STEP_GAIN;
        end
      end
      acs_pkg::ACS_STEP_GAIN: begin
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff == acs_pkg::STEP_LAST) begin
          nxt_cnt  = '0;
          // Gain-only selection ends here
          nxt_step = (sub_ff == acs_pkg::SUB_GAIN) ?
                     acs_pkg::ACS_STEP_NONE :
                     acs_pkg::ACS_STEP_OFFSET;
        end
      end
      acs_pkg::ACS_STEP_OFFSET: begin
        nxt_cnt = cnt_ff + 1'b1;
        if (cnt_ff == acs_pkg::STEP_LAST) begin
          nxt_cnt  = '0;
          nxt_step = acs_pkg::ACS_STEP_NONE;
        end
      end
    endcase
  end

  // Registers, frozen while the clock enable is low
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      step_ff <= acs_pkg::ACS_STEP_NONE;
      cnt_ff  <= '0;
      sub_ff  <= acs_pkg::SUB_FULL;
      sys_ff  <= 1'b0;
    end else if (i_clk_en) begin
      step_ff <= nxt_step;
      cnt_ff  <= nxt_cnt;
      sub_ff  <= nxt_sub;
      sys_ff  <= nxt_sys;
    end
  end

  assign cal.busy = (step_ff != acs_pkg::ACS_STEP_NONE);
  assign cal.step = step_ff;

endmodule

// ==== verif/acs_ctrl_monitor.sv ====
// Concurrent checks on status word and decode outputs of acs_ctrl.
// Assumes i_clk_en only drops while the block is idle.
`timescale 1ns/1ps
module acs_ctrl_monitor (
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  input wire logic        i_conv_busy,
  input wire logic [15:0] o_rd_data,
  input wire logic        o_rd_valid,
  input wire logic [1:0]  o_rd_target,
  input wire logic [1:0]  o_power_saving,
  input wire logic        o_neg_is_gnd,
  input wire logic        o_bipolar,
  input wire logic        o_chan_unused,
  input wire logic        o_cal_busy,
  input wire logic        o_cal_system,
  input wire logic [15:0] o_status
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // ----------------------------------------------------------
  // Fixed bits; ones only land one edge after reset
  // ----------------------------------------------------------
  property p_zero; o_status[15:14] == 2'h0; endproperty
  a_zero: assert property (p_zero)
    else $error("status top bits not zero");
  property p_ones; !$past(i_rst) |-> o_status[7:6] == 2'h3; endproperty
  a_ones: assert property (p_ones)
    else $error("status bits 7:6 not one");
  property p_rd_off;
    o_rd_valid && o_rd_target != 2'h3 |-> o_rd_data == 16'h0000;
  endproperty
  a_rd_off: assert property (p_rd_off)
    else $error("read with other target not zero");
  // ----------------------------------------------------------
  // Busy and calibration progress
  // ----------------------------------------------------------
  property p_calbit; o_status[0] == o_cal_busy; endproperty
  a_calbit: assert property (p_calbit)
    else $error("status bit 0 differs from cal busy");
  property p_busy;
    (o_cal_busy || $past(i_conv_busy)) && !$past(i_rst) |-> o_status[4];
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy bit low while active");
  property p_cal_min; $rose(o_cal_busy) |-> o_cal_busy[*8]; endproperty
  a_cal_min: assert property (p_cal_min)
    else $error("calibration ended too soon");
  property p_cal_end; $rose(o_cal_busy) |-> ##[100:301] !o_cal_busy;
  endproperty
  a_cal_end: assert property (p_cal_end)
    else $error("calibration did not end in time");
  // ----------------------------------------------------------
  // Mirrors and decode agree with each other
  // ----------------------------------------------------------
  property p_pwr; o_status[9:8] == o_power_saving; endproperty
  a_pwr: assert property (p_pwr)
    else $error("power field mirror wrong");
  property p_type; o_status[3] == o_cal_system; endproperty
  a_type: assert property (p_type)
    else $error("cal type mirror wrong");
  property p_unused; o_chan_unused |-> o_status[13:12] == 2'h1; endproperty
  a_unused: assert property (p_unused)
    else $error("unused code flagged wrongly");
  property p_dbip; !o_status[13] |-> o_bipolar == o_status[5]; endproperty
  a_dbip: assert property (p_dbip)
    else $error("differential coding wrong");
  property p_gnd;
    o_neg_is_gnd |-> o_status[13] && !o_status[5] && !o_bipolar;
  endproperty
  a_gnd: assert property (p_gnd)
    else $error("ground select wrong");
endmodule
bind acs_ctrl acs_ctrl_monitor u_acs_ctrl_monitor (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_conv_busy(i_conv_busy),
  .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
  .o_rd_target(o_rd_target), .o_power_saving(o_power_saving),
  .o_neg_is_gnd(o_neg_is_gnd), .o_bipolar(o_bipolar),
  .o_chan_unused(o_chan_unused), .o_cal_busy(o_cal_busy),
  .o_cal_system(o_cal_system), .o_status(o_status));

// ==== verif/acs_host_model.sv ====
// Host processor model on the parallel port pins.
// Assumes the bench calls one task at a time.
`timescale 1ns/1ps
module acs_host_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rd_valid,
  input  wire logic [15:0] i_rd_data,
  output logic             o_wr_stb,
  output logic             o_rd_stb,
  output logic      [15:0] o_wr_data
);
  initial o_wr_stb = 1'b0;
  initial o_rd_stb = 1'b0;
  initial o_wr_data = 16'h0000;
  // Strobe high 3 cycles; data held 4 more to cover the sync delay
  task automatic write_cw(input logic [15:0] w);
    @(posedge i_sys_clk);
    #1 o_wr_data = w;
    o_wr_stb = 1'b1;
    repeat (3) @(posedge i_sys_clk);
    #1 o_wr_stb = 1'b0;
    repeat (4) @(posedge i_sys_clk);
    #1 o_wr_data = ~w; // Released bus shows no stale word
    repeat (2) @(posedge i_sys_clk);
  endtask
  // Hold strobe until valid is sampled, then low 3 cycles
  task automatic read_word(output logic [15:0] d);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    #1 o_rd_stb = 1'b1;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (i_rd_valid !== 1'b1 && n < 20);
    d = (n < 20) ? i_rd_data : 16'hxxxx;
    #1 o_rd_stb = 1'b0;
    repeat (3) @(posedge i_sys_clk);
  endtask
endmodule

// ==== verif/tb.sv ====
// Self-checking bench for acs_ctrl with a host model on its pins.
// Assumes acs_pkg and acs_cal_if are compiled first.
`timescale 1ns/1ps
`define CHK(G, E) begin n_compared++; if ((G) !== (E)) begin n_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, G, E); end end
module tb;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_conv_busy = 1'b0;
  logic clk_en = 1'b1;
  logic wr_stb, rd_stb, rd_valid, conv_start, neg_gnd, bip, unused;
  logic cal_busy, cal_sys;
  logic [15:0] wr_data, rd_data, status, w, got;
  logic [1:0] rd_tgt, pwr, cal_step, prev_step = 2'h0;
  logic [2:0] pos_mux, neg_mux;
  logic [1:0] stq[$], e[$];
  int n_errors = 0, n_compared = 0, cycles = 0, seed = 6787;
  int n_conv = 0;
  int tq[$];
  int i, k, n;
  logic [31:0] r;
  always #5 i_sys_clk = ~i_sys_clk;
  acs_host_model u_acs_host_model (.i_sys_clk(i_sys_clk),
    .i_rd_valid(rd_valid), .i_rd_data(rd_data), .o_wr_stb(wr_stb),
    .o_rd_stb(rd_stb), .o_wr_data(wr_data));
  acs_ctrl u_acs_ctrl (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_clk_en(clk_en), .i_wr_stb(wr_stb), .i_rd_stb(rd_stb),
    .i_wr_data(wr_data), .i_conv_busy(i_conv_busy),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_rd_target(rd_tgt),
    .o_power_saving(pwr), .o_conv_start(conv_start),
    .o_pos_mux(pos_mux), .o_neg_mux(neg_mux), .o_neg_is_gnd(neg_gnd),
    .o_bipolar(bip), .o_chan_unused(unused), .o_cal_busy(cal_busy),
    .o_cal_system(cal_sys), .o_cal_step(cal_step), .o_status(status));
  // Step log with change times, start pulses, and timeout last
  always @(posedge i_sys_clk) begin
    cycles++;
    if (conv_start === 1'b1) n_conv++;
    if (cal_step !== prev_step) tq.push_back(cycles);
    if (cal_step !== prev_step && cal_step !== 2'h0) stq.push_back(cal_step);
    prev_step <= cal_step;
    if (cycles > 20000) begin
      n_errors++;
      summarize();
    end
  end
  task summarize;
    if (n_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Reference status word from the last control word
  function automatic logic [15:0] exp_st(logic [15:0] c, logic cal,
                                         logic cb);
    return {2'h0, c[13:8], 2'h3, c[5], cal | cb, c[3:1], cal};
  endfunction
  task automatic rd_chk(input logic [15:0] x);
    u_acs_host_model.read_word(got);
    `CHK(got, x)
  endtask
  // Reference mux and coding decode
  task automatic chk_mux(input logic [15:0] c);
    `CHK({rd_tgt, pwr, cal_sys}, {c[7:6], c[9:8], c[3]})
    if (c[13]) begin
      `CHK({pos_mux, neg_gnd, bip}, {c[11:10], c[12], ~c[5], 1'b0})
      if (c[5]) `CHK(neg_mux, acs_pkg::IN_EIGHT)
    end else begin
      `CHK({pos_mux, neg_mux}, {c[11:10], 1'b0, c[11:10], 1'b1})
      `CHK({neg_gnd, bip, unused}, {1'b0, c[5], c[12]})
    end
  endtask
  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (10) @(posedge i_sys_clk);
    `CHK(status, 16'h0000)
    #1 i_rst = 1'b0;
    repeat (3) @(posedge i_sys_clk);
    `CHK(status, 16'h00C0)
    // Every config, channel and range; random power and cal fields
    for (i = 0; i < 32; i++) begin
      r = $random(seed);
      w = {r[15:14], i[4:1], r[9:8], 2'h3, i[0], 1'b0, r[3:1], 1'b0};
      u_acs_host_model.write_cw(w);
      chk_mux(w);
      rd_chk(exp_st(w, 1'b0, 1'b0));
    end
    // Other read target answers zero
    u_acs_host_model.write_cw(16'h0000);
    u_acs_host_model.read_word(got);
    `CHK(got, 16'h0000)
    w = 16'h00CE; // Launch bit clear
    u_acs_host_model.write_cw(w);
    `CHK(cal_busy, 1'b0)
    #1 i_conv_busy = 1'b1;
    rd_chk(exp_st(w, 1'b0, 1'b1));
    #1 i_conv_busy = 1'b0;
    rd_chk(exp_st(w, 1'b0, 1'b0));
    w = 16'h00D0; // Conversion start bit: exactly one start pulse
    u_acs_host_model.write_cw(w);
    `CHK(n_conv, 1)
    rd_chk(exp_st(w, 1'b0, 1'b0));
    // All calibration kinds; a second launch mid-run is ignored
    for (k = 0; k < 8; k++) begin
      w = {8'h00, 2'h3, 2'h0, k[2:0], 1'b1};
      stq.delete();
      tq.delete();
      u_acs_host_model.write_cw(w);
      rd_chk(exp_st(w, 1'b1, 1'b0));
      if (k == 0) u_acs_host_model.write_cw(w);
      n = 0;
      while (cal_busy === 1'b1 && n < 400) begin
        @(posedge i_sys_clk);
        n++;
      end
      @(posedge i_sys_clk);
      `CHK(cal_busy, 1'b0)
      case (k[1:0])
        2'h0: e = '{2'h1, 2'h2, 2'h3};
        2'h1: e = '{2'h2, 2'h3};
        2'h2: e = '{2'h3};
        default: e = '{2'h2};
      endcase
      `CHK(stq.size(), e.size())
      foreach (e[j]) `CHK(stq[j], e[j])
      foreach (e[j]) `CHK(tq[j+1] - tq[j], acs_pkg::CAL_STEP_CYC)
      `CHK(cal_sys, k[2])
      rd_chk(exp_st(w, 1'b0, 1'b0));
    end
    // Clock enable low: a whole write goes unseen
    #1 clk_en = 1'b0;
    u_acs_host_model.write_cw(16'h3FC0);
    #1 clk_en = 1'b1;
    rd_chk(exp_st(w, 1'b0, 1'b0));
    summarize();
  end
endmodule
